// [src/mio_mirror_pkg.sv]
// constants and carriers for the multipurpose pin setup and uart status mirror
// assumes a pci target core that decodes local register dword accesses
package mio_mirror_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] pin_setup_off = 8'h04;
	localparam logic [7:0] fill_levels_off = 8'h08;
	localparam logic [7:0] irq_source_off = 8'h0c;

	////////////////////////////////////////////////////////////////////////////
	// multipurpose_pin_setup fields
	localparam int pin0_cfg_lsb = 0;
	localparam int pin1_cfg_lsb = 2;
	localparam int pin0_pme_bit = 4;
	localparam int pin1_pme_bit = 5;
	localparam int pin_setup_width = 6;
	localparam logic [5:0] pin_setup_rst = 6'h00;

	// pin mode codes
	localparam logic [1:0] mode_in_plain = 2'h0;
	localparam logic [1:0] mode_in_invert = 2'h1;
	localparam logic [1:0] mode_out_low = 2'h2;
	localparam logic [1:0] mode_out_high = 2'h3;

	////////////////////////////////////////////////////////////////////////////
	// uart_fill_levels_mirror fields
	localparam int rx0_lsb = 0;
	localparam int rx1_lsb = 8;
	localparam int tx0_lsb = 16;
	localparam int tx1_lsb = 24;
	localparam logic [7:0] level_rst = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// uart_irq_source_mirror fields
	localparam int isr0_lsb = 0;
	localparam int isr1_lsb = 6;
	localparam int good0_bit = 16;
	localparam int good1_bit = 17;
	localparam int good_all_bit = 31;
	localparam logic [5:0] isr_rst = 6'h01;
	localparam logic good_rst = 1'b1;

	// interrupt source codes that still count as good data
	localparam logic [5:0] isr_none = 6'h01;
	localparam logic [5:0] isr_rx_avail = 6'h04;
	localparam logic [5:0] isr_rx_timeout = 6'h0c;
	localparam logic [5:0] isr_tx_empty = 6'h02;

	// line status bits watched
	localparam int lsr_fifo_err_bit = 7;
	localparam int lsr_overrun_bit = 1;

	////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [7:0] rx_fill_level;
		logic [7:0] tx_fill_level;
		logic [5:0] interrupt_source_code;
		logic [7:0] line_status_word;
	} uart_status_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} reg_req_t;

endpackage

// [src/mio_config_and_uart_status_mirror.sv]
// multipurpose pin setup, pme routing and uart status mirror registers
// assumes the pci target core presents one decoded access per cycle and
// that each uart presents its live levels, source code and line status
//
// Summary of operation
// - bits 1:0 set pin 0 mode
// - bits 3:2 set pin 1 mode
// - bit 4 lets pin 0 raise pme
// - bit 5 lets pin 1 raise pme
// - external routing picks the affected function
// - fill levels packed rx0 rx1 tx0 tx1
// - fill levels track uart counters continuously
// - source codes at 5:0, 11:6, reset 01h
// - good flags at bits 16 and 17
// - bit 31 is and of good flags
// - good needs benign source code
// - good needs line status bit 7 clear
// - good needs line status bit 1 clear
// - line status read clears bit 7 upstream
// - mirrors sit at consecutive offsets 08h-0ch
// - global bits 26/27 route pins to functions
module mio_config_and_uart_status_mirror (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// local register access from the pci target
	input mio_mirror_pkg::reg_req_t req,
	output logic [31:0] rdata,
	output logic rd_ack,
	output logic hit,
	// uart live status
	input mio_mirror_pkg::uart_status_t uart0,
	input mio_mirror_pkg::uart_status_t uart1,
	// function routing from global status bits 26 and 27
	input wire logic [1:0] pin_route_fn1,
	// multipurpose pins
	input wire logic [1:0] multipurpose_pins_in,
	output logic [1:0] multipurpose_pins_out,
	output logic [1:0] multipurpose_pins_oe,
	// internal pin state and pme requests per function
	output logic [1:0] pin_state,
	output logic pme_req_fn0,
	output logic pme_req_fn1
);
	import mio_mirror_pkg::*;

	logic [5:0] multipurpose_pin_setup;
	logic [7:0] rx_level0, rx_level1, tx_level0, tx_level1;
	logic [5:0] isr0, isr1;
	logic good0, good1, good_all;
	logic next_good0, next_good1;
	logic [1:0] next_pin_state;
	logic [1:0] pme_hit;
	logic [31:0] next_rdata;
	logic sel_setup, sel_fill, sel_irq;

	////////////////////////////////////////////////////////////////////////////
	// address decode; the global status word at 10h lives elsewhere
	assign sel_setup = req.addr == pin_setup_off;
	assign sel_fill = req.addr == fill_levels_off;
	assign sel_irq = req.addr == irq_source_off;

	////////////////////////////////////////////////////////////////////////////
	// pin setup register; only byte lane 0 carries writable bits
	always_ff @(posedge clk) begin
		if (!rstn) begin
			multipurpose_pin_setup <= pin_setup_rst;
		end else if (req.wr && sel_setup && req.be[0]) begin
			multipurpose_pin_setup <= req.wdata[pin_setup_width-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin drivers and internal pin state, one slice per pin
	generate
		for (genvar p = 0; p < 2; p++) begin : g_pin
			logic [1:0] mode;
			assign mode = multipurpose_pin_setup[2*p +: 2];
			// an output pin reads as zero so it cannot fake a wake-up
			always_comb begin
				case (mode)
					mode_in_plain: next_pin_state[p] = multipurpose_pins_in[p];
					mode_in_invert: next_pin_state[p] = ~multipurpose_pins_in[p];
					default: next_pin_state[p] = 1'b0;
				endcase
			end
			always_ff @(posedge clk) begin
				if (!rstn) begin
					multipurpose_pins_oe[p] <= 1'b0;
					multipurpose_pins_out[p] <= 1'b0;
					pin_state[p] <= 1'b0;
				end else begin
					multipurpose_pins_oe[p] <= mode[1];
					multipurpose_pins_out[p] <= mode == mode_out_high;
					pin_state[p] <= next_pin_state[p];
				end
			end
			// pme only when this pin's enable bit is set
			assign pme_hit[p] = next_pin_state[p] & multipurpose_pin_setup[pin0_pme_bit+p];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// pme routing; the function choice comes from the global register bits
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pme_req_fn0 <= 1'b0;
			pme_req_fn1 <= 1'b0;
		end else begin
			pme_req_fn0 <= |(pme_hit & ~pin_route_fn1);
			pme_req_fn1 <= |(pme_hit & pin_route_fn1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// good-data evaluation from live uart status
	function automatic logic good_data(input uart_status_t u);
		logic benign;
		benign = u.interrupt_source_code == isr_none ||
			u.interrupt_source_code == isr_rx_avail ||
			u.interrupt_source_code == isr_rx_timeout ||
			u.interrupt_source_code == isr_tx_empty;
		return benign && !u.line_status_word[lsr_fifo_err_bit] &&
			!u.line_status_word[lsr_overrun_bit];
	endfunction

	// re-evaluated every cycle so a line status read upstream shows in the good flags at the next edge
	assign next_good0 = good_data(uart0);
	assign next_good1 = good_data(uart1);

	////////////////////////////////////////////////////////////////////////////
	// fill level shadows, refreshed every cycle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rx_level0 <= level_rst;
			rx_level1 <= level_rst;
			tx_level0 <= level_rst;
			tx_level1 <= level_rst;
		end else begin
			rx_level0 <= uart0.rx_fill_level;
			rx_level1 <= uart1.rx_fill_level;
			tx_level0 <= uart0.tx_fill_level;
			tx_level1 <= uart1.tx_fill_level;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// source code and good-data shadows; the and is taken from the same
	// samples so bit 31 never disagrees with bits 16 and 17
	always_ff @(posedge clk) begin
		if (!rstn) begin
			isr0 <= isr_rst;
			isr1 <= isr_rst;
			good0 <= good_rst;
			good1 <= good_rst;
			good_all <= good_rst;
		end else begin
			isr0 <= uart0.interrupt_source_code;
			isr1 <= uart1.interrupt_source_code;
			good0 <= next_good0;
			good1 <= next_good1;
			good_all <= next_good0 & next_good1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux; reserved bits and unmapped offsets read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (sel_setup) begin
			next_rdata[pin_setup_width-1:0] = multipurpose_pin_setup;
		end else if (sel_fill) begin
			next_rdata[rx0_lsb +: 8] = rx_level0;
			next_rdata[rx1_lsb +: 8] = rx_level1;
			next_rdata[tx0_lsb +: 8] = tx_level0;
			next_rdata[tx1_lsb +: 8] = tx_level1;
		end else if (sel_irq) begin
			next_rdata[isr0_lsb +: 6] = isr0;
			next_rdata[isr1_lsb +: 6] = isr1;
			next_rdata[good0_bit] = good0;
			next_rdata[good1_bit] = good1;
			next_rdata[good_all_bit] = good_all;
		end
	end

	// read answer one cycle after the request; rdata holds until the next read
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata <= 32'h0000_0000;
			rd_ack <= 1'b0;
			hit <= 1'b0;
		end else begin
			rd_ack <= req.rd;
			hit <= (req.rd || req.wr) && (sel_setup || sel_fill || sel_irq);
			if (req.rd) begin
				rdata <= next_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	sequence setup_write_s;
		req.wr && sel_setup && req.be[0];
	endsequence

	sequence setup_read_s;
		req.rd && sel_setup;
	endsequence

	pin_reset_a: assert property (@(posedge clk)
		$rose(rstn) |-> multipurpose_pins_oe == 2'b00 && multipurpose_pins_out == 2'b00)
		else $error("pins not released after reset");

	out_drive_a: assert property (@(posedge clk) disable iff (!rstn)
		setup_write_s ##1 (!req.wr)[*1] |=>
			multipurpose_pins_oe == {multipurpose_pin_setup[3], multipurpose_pin_setup[1]} &&
			multipurpose_pins_out[0] == (multipurpose_pin_setup[1:0] == mode_out_high))
		else $error("pin drive does not follow setup");

	setup_write_a: assert property (@(posedge clk) disable iff (!rstn)
		setup_write_s |=> multipurpose_pin_setup == $past(req.wdata[5:0]))
		else $error("setup write did not land");

	// the host stand-in never reads straight after a write, so readback is judged alone
	setup_readback_a: assert property (@(posedge clk) disable iff (!rstn)
		setup_read_s |=>
			rdata[5:0] == $past(multipurpose_pin_setup) && rdata[31:6] == 26'h0)
		else $error("setup readback wrong");

	pme_gate_a: assert property (@(posedge clk) disable iff (!rstn)
		!multipurpose_pin_setup[pin0_pme_bit] && !multipurpose_pin_setup[pin1_pme_bit]
			|=> !pme_req_fn0 && !pme_req_fn1)
		else $error("pme raised while disabled");

	pme_route_a: assert property (@(posedge clk) disable iff (!rstn)
		multipurpose_pin_setup[pin1_pme_bit] && next_pin_state[1] && pin_route_fn1[1]
			|=> pme_req_fn1)
		else $error("pin 1 pme not routed to function 1");

	invert_in_a: assert property (@(posedge clk) disable iff (!rstn)
		multipurpose_pin_setup[1:0] == mode_in_invert |=>
			pin_state[0] == !$past(multipurpose_pins_in[0]))
		else $error("inverted input state wrong");

	level_track_a: assert property (@(posedge clk) disable iff (!rstn)
		req.rd && sel_fill |=> rdata[tx1_lsb +: 8] == $past(uart1.tx_fill_level, 2)
			&& rdata[rx0_lsb +: 8] == $past(uart0.rx_fill_level, 2))
		else $error("fill level mirror stale");

	good_and_a: assert property (@(posedge clk) disable iff (!rstn)
		req.rd && sel_irq |=> rdata[good_all_bit] == (rdata[good0_bit] && rdata[good1_bit]))
		else $error("global good flag mismatch");

	overrun_bad_a: assert property (@(posedge clk) disable iff (!rstn)
		uart0.line_status_word[lsr_overrun_bit] |=> !good0 && !good_all)
		else $error("overrun left good flag set");

	fifo_err_a: assert property (@(posedge clk) disable iff (!rstn)
		uart1.line_status_word[lsr_fifo_err_bit] |=> !good1)
		else $error("fifo error left good flag set");

	isr_bad_a: assert property (@(posedge clk) disable iff (!rstn)
		uart0.interrupt_source_code == 6'h06 |=> !good0)
		else $error("receiver status code counted as good");

	irq_reset_a: assert property (@(posedge clk)
		$rose(rstn) |-> isr0 == isr_rst && isr1 == isr_rst && good0 && good1 && good_all)
		else $error("irq mirror reset values wrong");

	read_ack_a: assert property (@(posedge clk) disable iff (!rstn)
		req.rd && sel_irq |=> rd_ack && hit && rdata[good0_bit] == $past(good0))
		else $error("irq mirror read not answered");

	plain_in_a: assert property (@(posedge clk) disable iff (!rstn)
		multipurpose_pin_setup[3:2] == mode_in_plain |=>
			pin_state[1] == $past(multipurpose_pins_in[1]))
		else $error("plain input state wrong");

	out_state_a: assert property (@(posedge clk) disable iff (!rstn)
		multipurpose_pin_setup[1] |=>
			!pin_state[0])
		else $error("output pin state not zero");

	pme_fn0_a: assert property (@(posedge clk) disable iff (!rstn)
		multipurpose_pin_setup[pin0_pme_bit] && next_pin_state[0] && !pin_route_fn1[0]
			|=> pme_req_fn0)
		else $error("pin 0 pme not routed to function 0");

	pme1_gate_a: assert property (@(posedge clk) disable iff (!rstn)
		!multipurpose_pin_setup[pin1_pme_bit] && pin_route_fn1 == 2'b10
			|=> !pme_req_fn1)
		else $error("pin 1 pme raised while disabled");

	unmapped_hit_a: assert property (@(posedge clk) disable iff (!rstn)
		(req.rd || req.wr) && !sel_setup && !sel_fill && !sel_irq
			|=> !hit)
		else $error("unmapped offset reported a hit");

	irq_layout_a: assert property (@(posedge clk) disable iff (!rstn)
		req.rd && sel_irq |=> rdata[isr1_lsb +: 6] == $past(isr1)
			&& rdata[30:18] == 13'h0 && rdata[15:12] == 4'h0)
		else $error("irq mirror layout wrong");

	level_pack_a: assert property (@(posedge clk) disable iff (!rstn)
		req.rd && sel_fill |=> rdata[rx1_lsb +: 8] == $past(uart1.rx_fill_level, 2)
			&& rdata[tx0_lsb +: 8] == $past(uart0.tx_fill_level, 2))
		else $error("fill level packing wrong");

endmodule

// [verification/pci_host_model.sv]
// pci host stand-in issuing local register dword reads and writes
// assumes registered answers that settle at the taking edge, read 1 ns after it
module pci_host_model (
	// clock
	input wire logic clk,
	// register port
	output mio_mirror_pkg::reg_req_t req,
	input wire logic [31:0] rdata,
	input wire logic rd_ack,
	input wire logic hit
);
	timeunit 1ns;
	timeprecision 1ns;
	import mio_mirror_pkg::*;

	initial begin
		req = '0;
	end

	////////////////////////////////////////
	// one access; address and data turn to their inverse once taken, so stale values never help
	task automatic access(input logic w, input logic [7:0] addr, input logic [3:0] be,
		input logic [31:0] wdata, output logic [31:0] data, output logic [1:0] ans);
		@(posedge clk);
		req <= '{rd: ~w, wr: w, addr: addr, be: be, wdata: wdata};
		@(posedge clk);
		req <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, be: ~be, wdata: ~wdata};
		#1;
		data = rdata;
		ans = {rd_ack, hit};
	endtask
endmodule

// [verification/mio_config_and_uart_status_mirror_tb_top.sv]
// self-checking bench for the pin setup and uart status mirror block
// assumes the host stand-in, a behavioural pin wire and a uart status source
module mio_config_and_uart_status_mirror_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import mio_mirror_pkg::*;

	logic clk, rstn, rd_ack, hit, pme0, pme1;
	logic [1:0] route, ext, pins_in, pins_out, pins_oe, pin_state, a;
	logic [31:0] rdata, d;
	reg_req_t req;
	uart_status_t uart0, uart1;
	int errors, cmp_count;

	// pin wire: the block wins while it drives, the outside level otherwise
	assign pins_in = (pins_oe & pins_out) | (~pins_oe & ext);

	mio_config_and_uart_status_mirror u_mio_config_and_uart_status_mirror (.clk(clk),
		.rstn(rstn), .req(req), .rdata(rdata), .rd_ack(rd_ack), .hit(hit), .uart0(uart0),
		.uart1(uart1), .pin_route_fn1(route), .multipurpose_pins_in(pins_in),
		.multipurpose_pins_out(pins_out), .multipurpose_pins_oe(pins_oe),
		.pin_state(pin_state), .pme_req_fn0(pme0), .pme_req_fn1(pme1));
	pci_host_model u_pci_host_model (.clk(clk), .req(req), .rdata(rdata), .rd_ack(rd_ack),
		.hit(hit));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic rd(input logic [7:0] addr);
		u_pci_host_model.access(1'b0, addr, 4'h0, 32'h0, d, a);
	endtask
	task automatic wr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] v);
		u_pci_host_model.access(1'b1, addr, be, v, d, a);
	endtask
	// registered outputs follow one edge after an input change; settle waits two
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// {oe, out, state} for one pin
	function automatic logic [2:0] pin_exp(input logic [1:0] m, input logic e);
		return {m[1], m == mode_out_high, m == mode_in_plain ? e : (m == mode_in_invert) & ~e};
	endfunction
	task automatic wrap_up;
		if (errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////
	task automatic t_reset;
		check("reset outs", {rd_ack, hit, pins_oe, pins_out, pin_state, pme0, pme1}, 0);
		rstn <= 1'b1;
		rd(pin_setup_off);
		check("setup rst", d, 0);
		check("ack hit", a, 2'h3);
		rd(irq_source_off);
		check("irq rst", d, 32'h8003_0041);
	endtask
	task automatic t_modes;
		logic [2:0] e0, e1;
		for (int m = 0; m < 16; m++) begin
			wr(pin_setup_off, 4'h1, 32'hffff_ffc0 | m);
			@(posedge clk);
			ext <= m[1:0] ^ 2'h1;
			settle;
			e0 = pin_exp(m[1:0], ext[0]);
			e1 = pin_exp(m[3:2], ext[1]);
			check("pin oe", pins_oe, {e1[2], e0[2]});
			check("pin out", pins_out, {e1[1], e0[1]});
			check("pin state", pin_state, {e1[0], e0[0]});
			rd(pin_setup_off);
			check("setup rb", d, m);
		end
	endtask
	task automatic t_pme;
		logic [1:0] on;
		for (int c = 0; c < 32; c++) begin
			wr(pin_setup_off, 4'h1, {c[1:0], 4'h0});
			@(posedge clk);
			route <= c[3:2];
			ext <= c[4] ? 2'h0 : 2'h3;
			settle;
			on = c[1:0] & ext;
			check("pme fn0", pme0, |(on & ~route));
			check("pme fn1", pme1, |(on & route));
		end
	endtask
	task automatic t_levels;
		logic [7:0] n;
		for (int k = 0; k < 2; k++) begin
			// byte-wide step keeps every field of the expected word eight bits wide
			n = 8'(k);
			@(posedge clk);
			uart0.rx_fill_level <= 8'h12 + n;
			uart1.rx_fill_level <= 8'h34 + n;
			uart0.tx_fill_level <= 8'h56 + n;
			uart1.tx_fill_level <= 8'hff - n;
			// levels first, then status, as a driver burst would
			rd(fill_levels_off);
			check("levels", d, {8'hff - n, 8'h56 + n, 8'h34 + n, 8'h12 + n});
			rd(irq_source_off);
			check("burst hit", a, 2'h3);
		end
	endtask
	task automatic t_good;
		logic [5:0] codes[8];
		logic [7:0] lsrs[4];
		logic g0, g1;
		logic [31:0] want;
		codes = '{isr_none, isr_rx_avail, isr_rx_timeout, isr_tx_empty, 6'h06, 6'h00, 6'h10, 6'h3f};
		lsrs = '{8'h00, 8'h7d, 8'h80, 8'h02};
		for (int i = 0; i < 8; i++) begin
			for (int j = 0; j < 4; j++) begin
				@(posedge clk);
				// a line status read clears bit 7 in the uart, modelled by the next entry
				uart0.interrupt_source_code <= codes[i];
				uart0.line_status_word <= lsrs[j];
				// channel 1 runs offset so both flags, and bit 31, are seen set together
				uart1.interrupt_source_code <= codes[(i + 2) % 8];
				uart1.line_status_word <= lsrs[j ^ 1];
				g0 = i < 4 && j < 2;
				g1 = (i + 2) % 8 < 4 && j < 2;
				want = {g0 & g1, 13'h0, g1, g0, 4'h0, codes[(i + 2) % 8], codes[i]};
				rd(irq_source_off);
				check("irq src", d, want);
			end
		end
	endtask
	task automatic t_refuse;
		logic [31:0] keep;
		rd(fill_levels_off);
		keep = d;
		wr(fill_levels_off, 4'hf, 32'h0);
		// a write to a mapped read-only word is still decoded, so hit rises without ack
		check("ro hit", a, 2'h1);
		rd(fill_levels_off);
		check("ro levels", d, keep);
		wr(irq_source_off, 4'hf, 32'h0);
		wr(pin_setup_off, 4'h0, 32'h0);
		rd(pin_setup_off);
		check("be0 off", d, 32'h30);
		rd(8'h10);
		check("unmapped", d, 0);
		check("unm ack", a, 2'h2);
	endtask

	initial begin
		errors = 0;
		cmp_count = 0;
		rstn = 1'b0;
		route = 2'h0;
		ext = 2'h0;
		uart0 = {8'h00, 8'h00, isr_none, 8'h00};
		uart1 = {8'h00, 8'h00, isr_none, 8'h00};
		repeat (8) @(posedge clk);
		t_reset;
		t_modes;
		t_pme;
		t_levels;
		t_good;
		t_refuse;
		wrap_up;
	end

	// watchdog: whole run is well under a thousand cycles
	initial begin
		#200000;
		errors++;
		wrap_up;
	end
endmodule
